// ===== design/bus_err_pkg.sv
// Purpose: Shared constants and carriers for the bus error recorder
// Assumes: One system clock; codes of the bus interface listed below
// Notes:   Flag positions follow the error register layout

package bus_err_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ERR_FLAGS_OFS   = 8'h08;  // Error register
    localparam logic [31:0] ERR_FLAGS_RST   = 32'h0000_0000; // Loaded by sync reset
    localparam logic [31:0] HARD_MASK       = 32'h7FFF_0000; // Hard error bits 30:16
    localparam logic [31:0] SOFT_MASK       = 32'h0000_0007; // Soft error bits 2:0
    localparam logic [31:0] W1C_MASK        = 32'h7FFF_0007; // Write-one-to-clear bits
    localparam logic [31:0] RD_MASK         = 32'h7FFF_000F; // Readable bits

    // ----------------------------------------------------------------
    // Flag positions
    // ----------------------------------------------------------------
    localparam int B_INT_NOACK  = 30;
    localparam int B_TX_CHECK   = 29;
    localparam int B_CTRL_LINE  = 28;
    localparam int B_MST_PAR    = 27;
    localparam int B_INTERLOCK  = 26;
    localparam int B_DRV_FAULT  = 25;
    localparam int B_VEC_NOACK  = 24;
    localparam int B_CMD_PAR    = 23;
    localparam int B_SLV_PAR    = 22;
    localparam int B_SUBST      = 21;
    localparam int B_RETRY_TO   = 20;
    localparam int B_STALL_TO   = 19;
    localparam int B_START_TO   = 18;
    localparam int B_NO_RESP    = 17;
    localparam int B_BAD_CONF   = 16;
    localparam int B_PAR_MODE   = 3;
    localparam int B_ID_PAR     = 2;
    localparam int B_CORR       = 1;
    localparam int B_IDLE_PAR   = 0;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam int RETRY_LIMIT  = 4096;  // Consecutive retries
    localparam int STALL_LIMIT  = 128;   // Consecutive stall cycles
    localparam int START_LIMIT  = 4096;  // Cycles without a start

    // ----------------------------------------------------------------
    // Bus codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CYC_IDLE = 4'h0, CYC_CMD = 4'h1, CYC_READ_ACK = 4'h2, CYC_WR_DATA = 4'h3,
        CYC_BC_DATA = 4'h4, CYC_VEC_ACK = 4'h5, CYC_EMB_ARB = 4'h6, CYC_IDENT = 4'h7,
        CYC_WR_ACK = 4'h8, CYC_WR_STALL = 4'h9, CYC_BC_ACK = 4'hA
    } cyc_e;
    typedef enum logic [2:0] {
        TXN_OTHER = 3'h0, TXN_READ = 3'h1, TXN_WRITE = 3'h2, TXN_INTR = 3'h3,
        TXN_VECTOR = 3'h4, TXN_IDENT = 3'h5, TXN_LOCK_RD = 3'h6, TXN_UNLOCK_WR = 3'h7
    } txn_e;
    localparam logic [2:0] CNF_NACK  = 3'h0;  // No acknowledge
    localparam logic [2:0] CNF_ACK   = 3'h1;
    localparam logic [2:0] CNF_RETRY = 3'h2;
    localparam logic [2:0] CNF_STALL = 3'h3;  // Codes above are illegal
    localparam logic [1:0] RS_STALL  = 2'h2;  // Slave stall response
    typedef enum logic [1:0] {
        ST_GOOD = 2'h0, ST_CRD = 2'h1, ST_RDS = 2'h2, ST_RSVD = 2'h3
    } stat_e;

    // Observation from the bus interface, same clock
    typedef struct packed {
        logic        is_master;    // Node is bus master
        logic        loopback;     // Loopback cycle
        cyc_e        cyc;          // Current cycle type
        logic        parity_err;   // Parity check failed
        logic        parity_odd;   // Bus parity odd this cycle
        logic        id_par_err;   // Identifier line parity failed
        logic        drive_valid;  // Node drives data word
        logic [31:0] drive_word;   // Word driven
        logic [31:0] sense_word;   // Word read back
        txn_e        txn;          // Transaction kind
        logic        txn_done;     // Transaction completed
        logic        cnf_valid;    // Confirmation received
        logic [2:0]  cnf_code;     // Confirmation code
        logic        stat_valid;   // Status code received
        stat_e       stat;         // Status code
        logic        burst;        // Burst transfer
        logic        pend;         // Master request pending
        logic        started;      // Master transaction started
        logic [1:0]  slave_response_lines; // Slave port response
    } bus_obs_s;

    // Line drive intent, active high
    typedef struct packed {
        logic       arb_inhibit;
        logic       busy;
        logic [2:0] confirm;
    } line_drv_s;

endpackage

// ===== design/bus_error_recorder.sv
// Purpose: Sticky error flags for a backplane bus interface
// Assumes: Bus observation on sys_clk_i; line pins asynchronous, active low
// Notes:   One rule per line below
// Summary of operation
// - Each error sets its flag, the highest new one sets event code
// - Interrupt answered no-ack sets bit 30
// - Read-back mismatch sets 29, except arbitration
// - Driven control line seen high sets 28, arbitration line only outside bursts
// - Master read/vector data parity sets 27
// - Unlock write without pending sets 26
// - Parity error while driving parity sets 25
// - No driver fault during loopback
// - Unacknowledged interrupt vector sets bit 24
// - Command cycle error sets bit 23
// - Slave write/broadcast data parity sets 22
// - Substitute or reserved status sets 21
// - Retry limit from one node sets 20
// - Stall response held too long sets 19
// - No master start in limit sets 18
// - No-ack to clean read/write sets 17
// - Illegal confirmation code sets bit 16
// - Parity mode bit resets to zero
// - Identifier parity error sets bit 2
// - Master corrected status sets bit 1
// - Odd parity after idle pair sets 0
// - Hard bits 30:16, reserved read zero
// - Hard and soft summaries follow flags

`timescale 1ns/1ps
`default_nettype none

module bus_error_recorder
    import bus_err_pkg::*;
#(
    parameter int RETRY_MAX = RETRY_LIMIT,  // Retries before timeout
    parameter int STALL_MAX = STALL_LIMIT,  // Stall cycles before timeout
    parameter int START_MAX = START_LIMIT   // Cycles before start timeout
) (
    input  wire logic        sys_clk_i,              // System clock
    input  wire logic        srst_i,                 // Sync reset, active high
    input  wire bus_obs_s    obs_i,                  // Bus interface view
    input  wire line_drv_s   drv_i,                  // Lines being driven
    input  wire logic        arb_inhibit_line_n_i,   // Pin, active low
    input  wire logic        bus_busy_line_n_i,      // Pin, active low
    input  wire logic [2:0]  confirm_lines_n_i,      // Pins, active low
    input  wire logic        reg_wr_i,               // Register write strobe
    input  wire logic        reg_rd_i,               // Register read strobe
    input  wire logic [7:0]  reg_addr_i,             // Register byte offset
    input  wire logic [31:0] reg_wdata_i,            // Write data
    output logic      [31:0] reg_rdata_o,            // Read data
    output logic      [4:0]  event_code_o,           // Error event code
    output logic             event_valid_o,          // Event pulse
    output logic             hard_err_summary_o,     // Any hard flag
    output logic             soft_err_summary_o,     // Any soft flag
    output logic             unlock_pending_o,       // Locked read outstanding
    output logic             parity_mode_sel_o       // Parity mode bit
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] flags;        // Error register
        logic        unlock_pending;
        logic        cmd_ok;       // Last command cycle was clean
        logic [12:0] retry_cnt;    // Consecutive retries
        logic [12:0] stall_cnt;    // Consecutive stall cycles
        logic [12:0] start_cnt;    // Cycles pending without start
        line_drv_s   drv_p1;       // Drive intent, one cycle late
        line_drv_s   drv_p2;       // Drive intent, aligned to sync
        logic        burst_p1;
        logic        burst_p2;
        logic [4:0]  sync1;        // First sync stage
        logic [4:0]  sync2;        // Second sync stage
        logic        idle_prev;    // Idle lines last cycle
        logic [4:0]  event_code;
        logic        event_valid;
        logic [31:0] rdata;
    } state_s;

    state_s st_q;                  // Registered state
    state_s st_d;                  // Next state
    logic [31:0] set_v;            // Error events this cycle
    logic        mismatch;         // Read-back mismatch
    logic        par_master;       // Master owns parity
    logic        par_slave;        // Slave owns parity
    logic        line_idle;        // Arbitration and busy unasserted
    logic        clr_hit;          // Write to error register

    localparam logic [12:0] RETRY_TOP = 13'(RETRY_MAX);
    localparam logic [12:0] STALL_TOP = 13'(STALL_MAX);
    localparam logic [12:0] START_TOP = 13'(START_MAX);

    // ----------------------------------------------------------------
    // Error detection
    // ----------------------------------------------------------------
    always_comb begin
        set_v     = '0;
        mismatch  = obs_i.drive_valid && (obs_i.drive_word != obs_i.sense_word)
                    && (obs_i.cyc != CYC_EMB_ARB);
        par_master = (obs_i.cyc == CYC_CMD) || (obs_i.cyc == CYC_WR_DATA)
                    || (obs_i.cyc == CYC_BC_DATA) || (obs_i.cyc == CYC_EMB_ARB)
                    || (obs_i.cyc == CYC_IDENT);
        par_slave = (obs_i.cyc == CYC_READ_ACK) || (obs_i.cyc == CYC_VEC_ACK);
        // Sync stage 2 holds lines, low means asserted
        line_idle = st_q.sync2[4] && st_q.sync2[3];
        // Interrupt refused
        set_v[B_INT_NOACK] = obs_i.cnf_valid && (obs_i.cnf_code == CNF_NACK)
                    && (obs_i.txn == TXN_INTR);
        set_v[B_TX_CHECK] = mismatch;
        // Driven low line read back high
        set_v[B_CTRL_LINE] = (st_q.drv_p2.arb_inhibit && !st_q.burst_p2 && st_q.sync2[4])
                    || (st_q.drv_p2.busy && st_q.sync2[3])
                    || |(st_q.drv_p2.confirm & st_q.sync2[2:0]);
        set_v[B_MST_PAR] = obs_i.is_master && obs_i.parity_err
                    && par_slave;
        set_v[B_INTERLOCK] = obs_i.txn_done && (obs_i.txn == TXN_UNLOCK_WR)
                    && !st_q.unlock_pending;
        set_v[B_DRV_FAULT] = obs_i.parity_err && !obs_i.loopback
                    && ((obs_i.is_master && par_master)
                    || (!obs_i.is_master && par_slave));
        set_v[B_VEC_NOACK] = obs_i.cnf_valid && (obs_i.cnf_code == CNF_NACK)
                    && (obs_i.txn == TXN_VECTOR);
        set_v[B_CMD_PAR] = (obs_i.cyc == CYC_CMD)
                    && (obs_i.parity_err || mismatch);
        set_v[B_SLV_PAR] = !obs_i.is_master && obs_i.parity_err
                    && ((obs_i.cyc == CYC_WR_ACK) || (obs_i.cyc == CYC_WR_STALL)
                    || (obs_i.cyc == CYC_BC_ACK));
        set_v[B_SUBST] = obs_i.stat_valid && !obs_i.parity_err
                    && ((obs_i.stat == ST_RDS) || (obs_i.stat == ST_RSVD))
                    && ((obs_i.txn == TXN_READ) || (obs_i.txn == TXN_IDENT));
        set_v[B_RETRY_TO] = obs_i.is_master && obs_i.cnf_valid
                    && (obs_i.cnf_code == CNF_RETRY)
                    && (st_q.retry_cnt == RETRY_TOP - 13'h1);
        set_v[B_STALL_TO] = (obs_i.slave_response_lines == RS_STALL)
                    && (st_q.stall_cnt == STALL_TOP - 13'h1);
        set_v[B_START_TO] = obs_i.pend && !obs_i.started
                    && (st_q.start_cnt == START_TOP - 13'h1);
        set_v[B_NO_RESP] = obs_i.is_master && obs_i.cnf_valid
                    && (obs_i.cnf_code == CNF_NACK) && st_q.cmd_ok
                    && ((obs_i.txn == TXN_READ) || (obs_i.txn == TXN_WRITE));
        set_v[B_BAD_CONF] = obs_i.cnf_valid && (obs_i.cnf_code > CNF_STALL);
        set_v[B_ID_PAR] = (obs_i.cyc == CYC_EMB_ARB) && obs_i.id_par_err;
        set_v[B_CORR] = obs_i.is_master && obs_i.stat_valid && !obs_i.parity_err
                    && (obs_i.stat == ST_CRD);
        set_v[B_IDLE_PAR] = st_q.idle_prev && line_idle && obs_i.parity_odd;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        clr_hit = reg_wr_i && (reg_addr_i == ERR_FLAGS_OFS);
        // Pipeline drive intent to meet synchronised lines
        st_d.drv_p1   = drv_i;
        st_d.drv_p2   = st_q.drv_p1;
        st_d.burst_p1 = obs_i.burst;
        st_d.burst_p2 = st_q.burst_p1;
        st_d.sync1 = {arb_inhibit_line_n_i, bus_busy_line_n_i, confirm_lines_n_i};
        st_d.sync2 = st_q.sync1;
        st_d.idle_prev = line_idle;
        // Write-one clears, a same-cycle event wins
        if (clr_hit) begin
            st_d.flags = st_q.flags & ~(reg_wdata_i & W1C_MASK);
            st_d.flags[B_PAR_MODE] = reg_wdata_i[B_PAR_MODE];
        end
        st_d.flags = st_d.flags | (set_v & W1C_MASK);
        // Interlock tracking
        if (obs_i.txn_done && (obs_i.txn == TXN_LOCK_RD)) begin
            st_d.unlock_pending = 1'b1;
        end else if (obs_i.txn_done && (obs_i.txn == TXN_UNLOCK_WR)) begin
            st_d.unlock_pending = 1'b0;
        end
        // Command cycle quality for the no-responder check
        if (obs_i.cyc == CYC_CMD) begin
            st_d.cmd_ok = !(obs_i.parity_err || mismatch);
        end
        // Retry run, reset by any other master confirmation
        if (obs_i.is_master && obs_i.cnf_valid) begin
            if (obs_i.cnf_code != CNF_RETRY) begin
                st_d.retry_cnt = '0;
            end else if (st_q.retry_cnt == RETRY_TOP - 13'h1) begin
                st_d.retry_cnt = '0;
            end else begin
                st_d.retry_cnt = st_q.retry_cnt + 13'h1;
            end
        end
        // Stall run on the slave response
        if (obs_i.slave_response_lines != RS_STALL) begin
            st_d.stall_cnt = '0;
        end else if (st_q.stall_cnt == STALL_TOP - 13'h1) begin
            st_d.stall_cnt = '0;
        end else begin
            st_d.stall_cnt = st_q.stall_cnt + 13'h1;
        end
        // Pending time without a start
        if (!obs_i.pend || obs_i.started) begin
            st_d.start_cnt = '0;
        end else if (st_q.start_cnt == START_TOP - 13'h1) begin
            st_d.start_cnt = '0;
        end else begin
            st_d.start_cnt = st_q.start_cnt + 13'h1;
        end
        // Event code: highest new error, index plus one
        st_d.event_valid = |set_v;
        st_d.event_code  = '0;
        for (int i = 0; i < 32; i++) begin
            if (set_v[i]) begin
                st_d.event_code = 5'(i + 1);
            end
        end
        // Read data, reserved bits zero
        st_d.rdata = '0;
        if (reg_rd_i && (reg_addr_i == ERR_FLAGS_OFS)) begin
            st_d.rdata = st_q.flags & RD_MASK;
        end
        if (srst_i) begin
            st_d = '0;
            st_d.flags = ERR_FLAGS_RST;
            st_d.sync1 = 5'h1F;
            st_d.sync2 = 5'h1F;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o        = st_q.rdata;
    assign event_code_o       = st_q.event_code;
    assign event_valid_o      = st_q.event_valid;
    assign hard_err_summary_o = |(st_q.flags & HARD_MASK);
    assign soft_err_summary_o = |(st_q.flags & SOFT_MASK);
    assign unlock_pending_o   = st_q.unlock_pending;
    assign parity_mode_sel_o  = st_q.flags[B_PAR_MODE];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_event_flag_pair: assert property (|set_v |=> event_valid_o
        && (($past(set_v) & W1C_MASK) & ~st_q.flags) == 32'h0)
        else $error("error event without flag or event code");
    a_intr_noack_set: assert property (
        obs_i.cnf_valid && obs_i.cnf_code == CNF_NACK && obs_i.txn == TXN_INTR
        |=> st_q.flags[B_INT_NOACK])
        else $error("interrupt no-ack not recorded");
    a_arb_no_check: assert property (
        obs_i.cyc == CYC_EMB_ARB && !(clr_hit && reg_wdata_i[B_TX_CHECK])
        |=> st_q.flags[B_TX_CHECK] == $past(st_q.flags[B_TX_CHECK]))
        else $error("transmit check during arbitration");
    a_loopback_nofault: assert property (
        obs_i.loopback && !st_q.flags[B_DRV_FAULT] |=> !st_q.flags[B_DRV_FAULT])
        else $error("driver fault set in loopback");
    a_stall_limit: assert property (
        obs_i.slave_response_lines != RS_STALL
        ##1 (obs_i.slave_response_lines == RS_STALL) [*8]
        |-> st_q.stall_cnt == 13'h7 || STALL_MAX < 8)
        else $error("stall counter off");
    a_start_count: assert property (
        obs_i.pend && !obs_i.started |=> st_q.start_cnt != 13'h0 || START_MAX == 1
        || $past(st_q.start_cnt) == START_TOP - 13'h1)
        else $error("start counter not advancing");
    a_no_resp_clean: assert property (
        set_v[B_NO_RESP] |-> st_q.cmd_ok && !set_v[B_CMD_PAR])
        else $error("no-responder after bad command");
    a_reserved_zero: assert property (
        $past(reg_rd_i) |-> (reg_rdata_o & ~RD_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    a_summary_track: assert property (
        (set_v & HARD_MASK) != 32'h0 |=> hard_err_summary_o)
        else $error("hard summary does not follow flags");
    a_soft_summary: assert property (
        (set_v & SOFT_MASK) != 32'h0 |=> soft_err_summary_o)
        else $error("soft summary does not follow flags");
    a_sticky_hold: assert property (
        st_q.flags[B_CORR] && !(clr_hit && reg_wdata_i[B_CORR]) |=> st_q.flags[B_CORR])
        else $error("flag dropped without clear");
    a_clear_takes: assert property (
        clr_hit && reg_wdata_i[B_CORR] && !set_v[B_CORR] |=> !st_q.flags[B_CORR])
        else $error("write one did not clear flag");
    a_read_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside read");
    a_unlock_track: assert property (
        obs_i.txn_done && obs_i.txn == TXN_LOCK_RD |=> unlock_pending_o)
        else $error("locked read did not set pending");

endmodule

`default_nettype wire

// ===== test/bus_node_model.sv
// Purpose: Other bus nodes on the wired-low control lines
// Assumes: Pull-ups on every line; drv_i intent active high
// Notes:   stuck_i lets the lines float high while the device drives

`timescale 1ns/1ps
`default_nettype none

module bus_node_model
    import bus_err_pkg::*;
(
    input  wire logic      stuck_i,   // Fault: lines stay released
    input  wire line_drv_s drv_i,     // Device drive intent
    output logic           arb_n_o,   // No-arbitration pin
    output logic           busy_n_o,  // Busy pin
    output logic [2:0]     conf_n_o   // Confirmation pins
);
    // Released lines rise to the pull-up level
    assign arb_n_o  = stuck_i | ~drv_i.arb_inhibit;
    assign busy_n_o = stuck_i | ~drv_i.busy;
    assign conf_n_o = stuck_i ? 3'h7 : ~drv_i.confirm;
endmodule

`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the bus error recorder
// Assumes: Shortened counts for retry, stall and start limits
// Notes:   Expected flags are built from the mask of each scenario

`timescale 1ns/1ps
`default_nettype none

module tb
    import bus_err_pkg::*;
;
    localparam int RM = 16;
    localparam int SM = 8;
    localparam int BM = 16;
    localparam logic [31:0] ONE = 32'h1;
    logic        clk = 1'h0, srst = 1'h1, stuck = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [7:0]  addr = 8'h08;
    logic [31:0] wdata = 32'h0, rdata, exp_mode = 32'h0, lfsr = 32'hE179;
    logic [4:0]  ev_code;
    logic        ev_v, hs, ss, up, pm, arb_n, busy_n;
    logic [2:0]  conf_n;
    bus_obs_s    obs = '0, base = '0;
    line_drv_s   drv = '0;
    int          n_errors = 0, check_count = 0, k;

    bus_error_recorder #(.RETRY_MAX(RM), .STALL_MAX(SM), .START_MAX(BM)) u_bus_error_recorder (
        .sys_clk_i(clk), .srst_i(srst), .obs_i(obs), .drv_i(drv),
        .arb_inhibit_line_n_i(arb_n), .bus_busy_line_n_i(busy_n), .confirm_lines_n_i(conf_n),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .event_code_o(ev_code), .event_valid_o(ev_v),
        .hard_err_summary_o(hs), .soft_err_summary_o(ss), .unlock_pending_o(up),
        .parity_mode_sel_o(pm));
    bus_node_model u_bus_node_model (.stuck_i(stuck), .drv_i(drv), .arb_n_o(arb_n),
        .busy_n_o(busy_n), .conf_n_o(conf_n));

    // 250 MHz clock
    initial forever #2 clk = ~clk;

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, e, s);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'h1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic reg_rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        rd <= 1'h1; addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 cmp("rdata", e, rdata);
    endtask

    task automatic quiet(int n);
        repeat (n) begin
            #1 cmp("ev_valid", 32'h0, {31'h0, ev_v});
            @(posedge clk);
        end
    endtask

    // Wait for the event, then check code, summaries, flags and clearing
    task automatic expect_ev(logic [31:0] m, int bound);
        int i;
        int hi;
        hi = 0;
        for (i = 0; i < 32; i++) if (m[i]) hi = i + 1;
        #1;
        for (i = 0; i < bound && ev_v !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        cmp("ev_valid", 32'h1, {31'h0, ev_v});
        if (ev_v !== 1'h1) tally_and_finish();
        cmp("ev_code", 32'(hi), {27'h0, ev_code});
        cmp("hard_sum", {31'h0, (m & HARD_MASK) != 0}, {31'h0, hs});
        cmp("soft_sum", {31'h0, (m & SOFT_MASK) != 0}, {31'h0, ss});
        reg_rd(ERR_FLAGS_OFS, m | exp_mode);
        reg_wr(ERR_FLAGS_OFS, W1C_MASK | exp_mode);
        reg_rd(ERR_FLAGS_OFS, exp_mode);
    endtask

    // Present one observation for n cycles on top of base
    task automatic run(cyc_e c, txn_e t, logic [7:0] f, logic [2:0] cc, stat_e st,
                       int n, logic [31:0] m);
        bus_obs_s o;
        o = base;
        o.cyc = c;
        o.txn = t;
        {o.parity_odd, o.id_par_err, o.txn_done, o.stat_valid, o.cnf_valid,
         o.parity_err, o.loopback, o.is_master} = f;
        o.cnf_code = cc;
        o.stat = st;
        @(posedge clk);
        obs <= o;
        repeat (n) @(posedge clk);
        obs <= '0;
        if (m == 32'h0) quiet(4);
        else expect_ev(m, 8);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        reg_rd(ERR_FLAGS_OFS, ERR_FLAGS_RST);
        lfsr = lfsr_next(lfsr);
        reg_wr(ERR_FLAGS_OFS, lfsr | 32'h8);
        exp_mode = 32'h8;
        reg_rd(ERR_FLAGS_OFS, exp_mode);
        #1 cmp("mode_pin", 32'h1, {31'h0, pm});
        reg_wr(8'h0C, 32'hFFFF_FFFF);
        reg_rd(8'h0C, 32'h0);
        reg_rd(ERR_FLAGS_OFS, exp_mode);
        run(CYC_IDLE, TXN_INTR, 8'h09, CNF_NACK, ST_GOOD, 1, ONE << B_INT_NOACK);
        run(CYC_IDLE, TXN_VECTOR, 8'h09, CNF_NACK, ST_GOOD, 1, ONE << B_VEC_NOACK);
        run(CYC_CMD, TXN_READ, 8'h01, 3'h1, ST_GOOD, 1, 32'h0);
        run(CYC_IDLE, TXN_READ, 8'h09, CNF_NACK, ST_GOOD, 1, ONE << B_NO_RESP);
        run(CYC_IDLE, TXN_OTHER, 8'h09, CNF_NACK, ST_GOOD, 1, 32'h0);
        for (k = 4; k < 8; k++) run(CYC_IDLE, TXN_READ, 8'h09, 3'(k), ST_GOOD, 1, ONE << B_BAD_CONF);
        run(CYC_IDLE, TXN_READ, 8'h09, CNF_RETRY, ST_GOOD, RM, ONE << B_RETRY_TO);
        run(CYC_READ_ACK, TXN_READ, 8'h05, 3'h1, ST_GOOD, 1, ONE << B_MST_PAR);
        run(CYC_WR_DATA, TXN_WRITE, 8'h05, 3'h1, ST_GOOD, 1, ONE << B_DRV_FAULT);
        run(CYC_WR_DATA, TXN_WRITE, 8'h07, 3'h1, ST_GOOD, 1, 32'h0);
        run(CYC_CMD, TXN_READ, 8'h05, 3'h1, ST_GOOD, 1, 32'h0280_0000);
        run(CYC_CMD, TXN_READ, 8'h07, 3'h1, ST_GOOD, 1, ONE << B_CMD_PAR);
        run(CYC_IDLE, TXN_READ, 8'h09, CNF_NACK, ST_GOOD, 1, 32'h0);
        run(CYC_WR_ACK, TXN_WRITE, 8'h04, 3'h1, ST_GOOD, 1, ONE << B_SLV_PAR);
        run(CYC_READ_ACK, TXN_READ, 8'h11, 3'h1, ST_RDS, 1, ONE << B_SUBST);
        run(CYC_VEC_ACK, TXN_IDENT, 8'h11, 3'h1, ST_RSVD, 1, ONE << B_SUBST);
        run(CYC_READ_ACK, TXN_READ, 8'h11, 3'h1, ST_CRD, 1, ONE << B_CORR);
        run(CYC_EMB_ARB, TXN_OTHER, 8'h40, 3'h1, ST_GOOD, 1, ONE << B_ID_PAR);
        run(CYC_IDLE, TXN_OTHER, 8'h80, 3'h1, ST_GOOD, 1, ONE << B_IDLE_PAR);
        run(CYC_IDLE, TXN_LOCK_RD, 8'h21, 3'h1, ST_GOOD, 1, 32'h0);
        #1 cmp("unlock_pending", 32'h1, {31'h0, up});
        run(CYC_IDLE, TXN_UNLOCK_WR, 8'h21, 3'h1, ST_GOOD, 1, 32'h0);
        run(CYC_IDLE, TXN_UNLOCK_WR, 8'h21, 3'h1, ST_GOOD, 1, ONE << B_INTERLOCK);
        base.pend = 1'h1;
        run(CYC_IDLE, TXN_OTHER, 8'h01, 3'h1, ST_GOOD, BM, ONE << B_START_TO);
        base = '0;
        base.slave_response_lines = RS_STALL;
        run(CYC_IDLE, TXN_OTHER, 8'h00, 3'h1, ST_GOOD, SM, ONE << B_STALL_TO);
        base = '0;
        base.drive_valid = 1'h1;
        lfsr = lfsr_next(lfsr);
        base.drive_word = lfsr;
        base.sense_word = lfsr;
        run(CYC_WR_DATA, TXN_WRITE, 8'h01, 3'h1, ST_GOOD, 1, 32'h0);
        base.sense_word = lfsr ^ 32'h4;
        run(CYC_EMB_ARB, TXN_OTHER, 8'h01, 3'h1, ST_GOOD, 1, 32'h0);
        run(CYC_WR_DATA, TXN_WRITE, 8'h01, 3'h1, ST_GOOD, 1, ONE << B_TX_CHECK);
        base = '0;
        @(posedge clk);
        drv.busy <= 1'h1;
        quiet(4);
        drv.busy <= 1'h0;
        quiet(4);
        drv.busy <= 1'h1;
        stuck <= 1'h1;
        @(posedge clk);
        drv.busy <= 1'h0;
        stuck <= 1'h0;
        expect_ev(ONE << B_CTRL_LINE, 8);
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
